// file: rtl/sbt_timer.sv
// sixteen_bit_timer: 16-bit up counter with source mux, prescaler and bit-edge interrupt
// assumes clock-source inputs are synchronous levels; io port is the core's register strobe
module sbt_timer (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire sbt_pkg::sbt_clk_src_type src_i,
  input wire sbt_pkg::sbt_io_type io_i,
  input wire logic store_i,
  input wire logic [15:0] store_data_i,
  input wire logic load_i,
  output logic [7:0] io_rdata_o,
  output logic [15:0] load_data_o,
  output logic irq_pulse_o,
  output logic [7:0] mode_o
);
  import sbt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_r;
  logic edge_sel_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [SBT_PRE_W-1:0] pre_r;
  logic src_d_r;
  logic sel_d_r;
  logic [7:0] io_rdata_r;
  logic [15:0] load_r;
  logic irq_r;

  wire sbt_src_type src_sel = sbt_src_type'(mode_r[SBT_SRC_HI:SBT_SRC_LO]);
  wire sbt_pre_type pre_sel = sbt_pre_type'(mode_r[SBT_PRE_HI:SBT_PRE_LO]);
  wire [2:0] bit_sel = mode_r[SBT_SEL_HI:SBT_SEL_LO];

  wire src_lvl = (src_sel == SBT_SRC_PA4) ? src_i.pin_a4_clock_input :
                 (src_sel == SBT_SRC_FRC) ? src_i.fast_internal_rc :
                 (src_sel == SBT_SRC_XTAL) ? src_i.crystal_oscillator :
                 (src_sel == SBT_SRC_SRC) ? src_i.slow_internal_rc :
                 (src_sel == SBT_SRC_PA0) ? src_i.pin_a0_clock_input : 1'b0;
  // core clock counts every cycle; external sources count on rising edges only
  wire src_tick = (src_sel == SBT_SRC_CORE) ? 1'b1 :
                  ((src_sel == SBT_SRC_STOP) || (src_sel == SBT_SRC_NONE)) ? 1'b0 :
                  (src_lvl & ~src_d_r);

  wire [SBT_PRE_W-1:0] pre_next = pre_r + 6'h01;
  wire pre_tc = (pre_sel == SBT_DIV1) ? 1'b1 :
                (pre_sel == SBT_DIV4) ? ((pre_r & SBT_DIV4_LAST) == SBT_DIV4_LAST) :
                (pre_sel == SBT_DIV16) ? ((pre_r & SBT_DIV16_LAST) == SBT_DIV16_LAST) :
                ((pre_r & SBT_DIV64_LAST) == SBT_DIV64_LAST);
  wire cnt_tick = src_tick & pre_tc;

  wire [15:0] count_inc = count_r + 16'h0001;
  // store has priority over a coincident tick
  assign count_nxt = store_i ? store_data_i : (cnt_tick ? count_inc : count_r);

  wire sel_bit = count_r[SBT_SEL_BASE + int'(bit_sel)];
  // edge choice; one matching edge per 2^(n+9) ticks for select code n
  wire irq_evt = edge_sel_r ? (sel_d_r & ~sel_bit) : (~sel_d_r & sel_bit);

  wire mode_wr = io_i.io_wr && (io_i.io_addr == SBT_MODE_ADDR);
  wire edge_wr = io_i.io_wr && (io_i.io_addr == SBT_EDGE_ADDR);
  wire [7:0] rd_mux = (io_i.io_addr == SBT_MODE_ADDR) ? mode_r :
                      (io_i.io_addr == SBT_EDGE_ADDR) ? (8'h01 << SBT_EDGE_BIT) & {8{edge_sel_r}} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= SBT_MODE_RESET;
      edge_sel_r <= 1'b0;
      count_r <= 16'h0000;
      pre_r <= 6'h00;
      src_d_r <= 1'b0;
      sel_d_r <= 1'b0;
      io_rdata_r <= 8'h00;
      load_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      if (mode_wr) begin
        mode_r <= io_i.io_wdata;
      end
      if (edge_wr) begin
        edge_sel_r <= io_i.io_wdata[SBT_EDGE_BIT];
      end
      if (io_i.io_rd) begin
        io_rdata_r <= rd_mux;
      end
      src_d_r <= src_lvl;
      if (src_tick) begin
        pre_r <= pre_tc ? 6'h00 : pre_next;
      end
      count_r <= count_nxt;
      // reference follows the selected bit, so a store or reselect that changes the selected bit value in the chosen edge direction gives an event
      sel_d_r <= sel_bit;
      if (load_i) begin
        load_r <= count_r;
      end
      // request pulse toward interrupt request bit 2
      irq_r <= irq_evt;
    end
  end

  assign io_rdata_o = io_rdata_r;
  assign load_data_o = load_r;
  assign irq_pulse_o = irq_r;
  assign mode_o = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  property p_store_loads;
    @(posedge core_clk_i) disable iff (rst_i) store_i |=> count_r == $past(store_data_i);
  endproperty
  a_store_loads: assert property (p_store_loads) else $error("store value not loaded");
  property p_up_only;
    @(posedge core_clk_i) disable iff (rst_i) !$past(store_i) && !$past(rst_i) |->
      (count_r == $past(count_r)) || (count_r == 16'($past(count_r) + 16'h0001));
  endproperty
  a_up_only: assert property (p_up_only) else $error("counter moved other than up by one");
  property p_wrap;
    @(posedge core_clk_i) disable iff (rst_i) (count_r == 16'hFFFF) && cnt_tick && !store_i |=> count_r == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");
  property p_stop;
    @(posedge core_clk_i) disable iff (rst_i) (src_sel == SBT_SRC_STOP) && !store_i |=> $stable(count_r);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped counter moved");
  property p_div4;
    @(posedge core_clk_i) disable iff (rst_i) (pre_sel == SBT_DIV4) && cnt_tick |-> pre_r[1:0] == 2'h3;
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four tick misplaced");
  property p_core_div1;
    @(posedge core_clk_i) disable iff (rst_i) (src_sel == SBT_SRC_CORE) && (pre_sel == SBT_DIV1) |-> cnt_tick;
  endproperty
  a_core_div1: assert property (p_core_div1) else $error("core clock divide by one missed a tick");
  property p_load;
    @(posedge core_clk_i) disable iff (rst_i) load_i |=> load_data_o == $past(count_r);
  endproperty
  a_load: assert property (p_load) else $error("load did not capture count");
  property p_rise;
    @(posedge core_clk_i) disable iff (rst_i) !edge_sel_r && !sel_d_r && sel_bit |=> irq_pulse_o;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  property p_fall;
    @(posedge core_clk_i) disable iff (rst_i) edge_sel_r && sel_d_r && !sel_bit |=> irq_pulse_o;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  property p_bit8;
    @(posedge core_clk_i) disable iff (rst_i) bit_sel == 3'h0 |-> sel_bit == count_r[8];
  endproperty
  a_bit8: assert property (p_bit8) else $error("code zero not bit eight");

  ////////////////////////////////////////////////////////////////////////////
  property p_count_step;
    @(posedge core_clk_i) disable iff (rst_i)
      (src_sel == SBT_SRC_CORE) && (pre_sel == SBT_DIV1) && !store_i |=>
      count_r == 16'($past(count_r) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("core clock count did not step by one");
  property p_div4_gap;
    @(posedge core_clk_i) disable iff (rst_i)
      ((src_sel == SBT_SRC_CORE) && (pre_sel == SBT_DIV4) && cnt_tick) ##1
      ((src_sel == SBT_SRC_CORE) && (pre_sel == SBT_DIV4)) [*4] |->
      cnt_tick && !$past(cnt_tick) && !$past(cnt_tick, 2) && !$past(cnt_tick, 3);
  endproperty
  a_div4_gap: assert property (p_div4_gap) else $error("divide by four ticks not four cycles apart");
  property p_ext_rise;
    @(posedge core_clk_i) disable iff (rst_i)
      (src_sel == SBT_SRC_PA4) && ($past(src_sel) == SBT_SRC_PA4) |->
      src_tick == (src_i.pin_a4_clock_input && !$past(src_i.pin_a4_clock_input));
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("pin clock tick not on rising level");
  property p_mode_write;
    @(posedge core_clk_i) disable iff (rst_i)
      mode_wr |=> mode_o == $past(io_i.io_wdata);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write not taken");
  property p_edge_write;
    @(posedge core_clk_i) disable iff (rst_i)
      edge_wr |=> edge_sel_r == $past(io_i.io_wdata[SBT_EDGE_BIT]);
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("edge choice write not taken");
  property p_rd_other;
    @(posedge core_clk_i) disable iff (rst_i)
      io_i.io_rd && (io_i.io_addr != SBT_MODE_ADDR) && (io_i.io_addr != SBT_EDGE_ADDR) |=>
      io_rdata_o == 8'h00;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("read of unmapped address not zero");
  property p_rd_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      !io_i.io_rd |=> $stable(io_rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_load_hold;
    @(posedge core_clk_i) disable iff (rst_i)
      !load_i |=> $stable(load_data_o);
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("count snapshot moved without a load");
  property p_wrong_edge;
    @(posedge core_clk_i) disable iff (rst_i)
      (edge_sel_r ? (!sel_d_r && sel_bit) : (sel_d_r && !sel_bit)) |=>
      !irq_pulse_o;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("event on the unselected edge");
  property p_quiet;
    @(posedge core_clk_i) disable iff (rst_i)
      (sel_d_r == sel_bit) |=> !irq_pulse_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event without a bit transition");
  c_irq: cover property (@(posedge core_clk_i) disable iff (rst_i) irq_pulse_o);
  c_wrap: cover property (@(posedge core_clk_i) disable iff (rst_i) count_r == 16'hFFFF ##1 count_r == 16'h0000);
  c_store: cover property (@(posedge core_clk_i) disable iff (rst_i) store_i ##1 cnt_tick);
  c_fall: cover property (@(posedge core_clk_i) disable iff (rst_i) edge_sel_r && irq_pulse_o);
  c_div4: cover property (@(posedge core_clk_i) disable iff (rst_i) (pre_sel == SBT_DIV4) && cnt_tick);
endmodule

// file: rtl/sbt_pkg.sv
// sixteen-bit interval timer: constants, field layout and carrier types
// assumes a single 10 MHz core clock and synchronous clock-source inputs
package sbt_pkg;
  localparam logic [7:0] SBT_MODE_ADDR = 8'h06;
  localparam logic [7:0] SBT_EDGE_ADDR = 8'h0C;
  localparam logic [7:0] SBT_MODE_RESET = 8'h00;
  localparam int SBT_SRC_HI = 7;
  localparam int SBT_SRC_LO = 5;
  localparam int SBT_PRE_HI = 4;
  localparam int SBT_PRE_LO = 3;
  localparam int SBT_SEL_HI = 2;
  localparam int SBT_SEL_LO = 0;
  localparam int SBT_EDGE_BIT = 5;
  localparam int SBT_IRQ_BIT = 2;
  localparam int SBT_SEL_BASE = 8;
  localparam int SBT_PRE_W = 6;
  localparam logic [SBT_PRE_W-1:0] SBT_DIV4_LAST = 6'h03;
  localparam logic [SBT_PRE_W-1:0] SBT_DIV16_LAST = 6'h0F;
  localparam logic [SBT_PRE_W-1:0] SBT_DIV64_LAST = 6'h3F;

  typedef enum logic [2:0] {
    SBT_SRC_STOP = 3'b000,
    SBT_SRC_CORE = 3'b001,
    SBT_SRC_NONE = 3'b010,
    SBT_SRC_PA4 = 3'b011,
    SBT_SRC_FRC = 3'b100,
    SBT_SRC_XTAL = 3'b101,
    SBT_SRC_SRC = 3'b110,
    SBT_SRC_PA0 = 3'b111
  } sbt_src_type;

  typedef enum logic [1:0] {
    SBT_DIV1 = 2'b00,
    SBT_DIV4 = 2'b01,
    SBT_DIV16 = 2'b10,
    SBT_DIV64 = 2'b11
  } sbt_pre_type;

  typedef struct packed {
    logic fast_internal_rc;
    logic slow_internal_rc;
    logic crystal_oscillator;
    logic pin_a4_clock_input;
    logic pin_a0_clock_input;
  } sbt_clk_src_type;

  typedef struct packed {
    logic io_wr;
    logic io_rd;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
  } sbt_io_type;
endpackage

// file: testbench/test_sbt_timer.sv
// bench for the sixteen-bit timer: source and divider table, then wrap, event, decode and reset cases
// assumes one 10 MHz clock; src_i levels may toggle every cycle
module test_sbt_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import sbt_pkg::*;
  typedef struct packed {logic [7:0] mode; logic [4:0] mask; logic [15:0] cyc; logic [15:0] dlt;} sbt_row_type;
  // deltas are taken between two loads, so the prescaler phase cannot skew them
  localparam sbt_row_type ROWS [12] = '{
    '{8'h20, 5'h00, 16'h0064, 16'h0064}, '{8'h28, 5'h00, 16'h0190, 16'h0064},
    '{8'h30, 5'h00, 16'h0640, 16'h0064}, '{8'h38, 5'h00, 16'h1900, 16'h0064},
    '{8'h00, 5'h1F, 16'h0064, 16'h0000}, '{8'h40, 5'h1F, 16'h0064, 16'h0000},
    '{8'h60, 5'h02, 16'h00C8, 16'h0064}, '{8'h80, 5'h10, 16'h00C8, 16'h0064},
    '{8'hA0, 5'h04, 16'h00C8, 16'h0064}, '{8'hC0, 5'h08, 16'h00C8, 16'h0064},
    '{8'hE0, 5'h01, 16'h00C8, 16'h0064}, '{8'hE8, 5'h01, 16'h0320, 16'h0064}};
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  sbt_clk_src_type src_i = '0;
  logic [4:0] mask = '0;
  sbt_io_type io_i = '0;
  logic store_i = 1'b0;
  logic [15:0] store_data_i = '0;
  logic load_i = 1'b0;
  logic [7:0] io_rdata_o;
  logic [15:0] load_data_o;
  logic irq_pulse_o;
  logic [7:0] mode_o;
  int errors = 0;
  int n_tests = 0;
  int n;
  logic [15:0] a, b;
  sbt_timer uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .src_i(src_i), .io_i(io_i), .store_i(store_i),
    .store_data_i(store_data_i), .load_i(load_i), .io_rdata_o(io_rdata_o), .load_data_o(load_data_o),
    .irq_pulse_o(irq_pulse_o), .mode_o(mode_o));
  always #50 core_clk_i = ~core_clk_i;
  // in the external-source rows only the selected line toggles, so a wrong mux choice counts nothing
  always @(posedge core_clk_i) src_i <= src_i ^ mask;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic io(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk_i) io_i <= '{w, ~w, ad, d};
    @(posedge core_clk_i) io_i <= '0;
    @(negedge core_clk_i);
  endtask
  task automatic ld(output logic [15:0] v);
    @(posedge core_clk_i) load_i <= 1'b1;
    @(posedge core_clk_i) load_i <= 1'b0;
    @(negedge core_clk_i) v = load_data_o;
  endtask
  task automatic wirq(input int lim, output int k);
    k = 0;
    do begin
      @(negedge core_clk_i);
      k++;
      if (k > lim) begin
        errors++;
        $display("mismatch at %0t: no timer event", $time);
        wrap_up();
      end
    end while (irq_pulse_o !== 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk({8'h00, mode_o}, 16'h0000);
    chk(load_data_o, 16'h0000);
    foreach (ROWS[i]) begin
      mask = ROWS[i].mask;
      io(1'b1, SBT_MODE_ADDR, ROWS[i].mode);
      io(1'b0, SBT_MODE_ADDR, 8'h00);
      chk({8'h00, io_rdata_o}, {8'h00, ROWS[i].mode});
      ld(a);
      repeat (ROWS[i].cyc - 2) @(posedge core_clk_i);
      ld(b);
      chk(b - a, ROWS[i].dlt);
    end
    // store near all ones, then count through zero
    io(1'b1, SBT_MODE_ADDR, 8'h20);
    @(posedge core_clk_i) store_data_i <= 16'hFFF0;
    store_i <= 1'b1;
    @(posedge core_clk_i) store_i <= 1'b0;
    ld(a);
    chk({4'h0, a[15:4]}, 16'h0FFF);
    repeat (30) @(posedge core_clk_i);
    ld(b);
    chk(b - a, 16'h0020);
    chk({15'h0000, b < a}, 16'h0001);
    // only the edge bit is kept, rising on bit 8
    io(1'b1, SBT_EDGE_ADDR, 8'hDF);
    io(1'b0, SBT_EDGE_ADDR, 8'h00);
    chk({8'h00, io_rdata_o}, 16'h0000);
    wirq(600, n);
    wirq(600, n);
    chk(n[15:0], 16'h0200);
    @(negedge core_clk_i) chk({15'h0000, irq_pulse_o}, 16'h0000);
    wirq(600, n);
    ld(a);
    chk({11'h000, a[8:4]}, 16'h0010);
    // falling edge on bit 9
    io(1'b1, SBT_EDGE_ADDR, 8'h20);
    io(1'b1, SBT_MODE_ADDR, 8'h21);
    // reselecting bit 9 while bit 8 is high is itself a falling edge
    wirq(1100, n);
    chk(n[15:0], 16'h0001);
    wirq(1100, n);
    wirq(1100, n);
    chk(n[15:0], 16'h0400);
    ld(a);
    chk({10'h000, a[9:4]}, 16'h0000);
    // unmapped address writes nothing and reads zero
    io(1'b1, 8'h07, 8'h55);
    io(1'b0, 8'h07, 8'h00);
    chk({8'h00, io_rdata_o}, 16'h0000);
    chk({8'h00, mode_o}, 16'h0021);
    @(posedge core_clk_i) rst_i <= 1'b1;
    @(negedge core_clk_i) chk({8'h00, mode_o}, 16'h0000);
    chk(load_data_o, 16'h0000);
    @(posedge core_clk_i) rst_i <= 1'b0;
    // mode comes back as stop, so the count stays at zero
    ld(a);
    chk(a, 16'h0000);
    wrap_up();
  end
endmodule
